/* rtl/spmf_consts.vh */
// Constants for the serial mode and error flag block
// Assumes inclusion by bare name from the rtl folder
`ifndef SPMF_CONSTS_VH
`define SPMF_CONSTS_VH
`define SPMF_ADDR_CTRL 4'h0
`define SPMF_ADDR_VIEW 4'h1
`define SPMF_ADDR_STAT 4'h2
`define SPMF_ADDR_MASK 4'h3
`define SPMF_ADDR_CFG 4'h4
`define SPMF_BIT_MODE_HI 7
`define SPMF_BIT_MODE_LO 6
`define SPMF_BIT_FE 7
`define SPMF_BIT_OV 6
`define SPMF_BIT_MP 5
`define SPMF_RST_CTRL 3'h0
`define SPMF_MODE0 2'h0
`define SPMF_MODE1 2'h1
`define SPMF_MODE2 2'h2
`define SPMF_MODE3 2'h3
`define SPMF_DIV_SLOW 4'hc
`define SPMF_DIV_FAST 4'h4
`endif

/* rtl/spmf_divider.v */
// Mode 0 shift clock divider: one-cycle enable every N system clocks
// Assumes a single clock and synchronous active-high reset
`timescale 1ns/100ps
module spmf_divider (
   input wire clock,
   input wire rst,
   input wire run,
   input wire [3:0] divide_by,
   output reg tick
);
   reg [3:0] count;
   always @(posedge clock) begin
      if (rst || !run) begin
         count <= 4'h0;
         tick <= 1'b0;
      end else if (count >= divide_by - 4'h1) begin
         count <= 4'h0;
         tick <= 1'b1;
      end else begin
         count <= count + 4'h1;
         tick <= 1'b0;
      end
   end
endmodule // spmf_divider

/* rtl/spmf_serial_mode.v */
// Serial control mode select, multiprocessor filter and error flags
// Assumes shift logic reports events as one-cycle pulses on the system clock
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "spmf_consts.vh"
//
// Contract
// - With view select 0, bits 7-6 choose one of four serial modes.
// - Frame error flag at bit 7 set by hardware, cleared by writing 0 at view 1.
// - Receive overrun flag at bit 6 set by hardware until software clears.
// - Bits 7-5 show controls at view 0, flags at view 1.
// - Mode 0 shift clock is 1/12 clock, or 1/4 with multiprocessor bit.
// - Mode 1 with multiprocessor bit sets receive flag only on stop bit 1.
// - Modes 2,3 with multiprocessor bit set receive flag only if ninth bit 1.
module spmf_serial_mode (
   input wire clock,
   input wire rst,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire frame_error_event,
   input wire overrun_event,
   input wire collision_event,
   input wire rx_done,
   input wire rx_stop_bit,
   input wire rx_ninth_bit,
   input wire shift_active,
   output reg [1:0] serial_mode_select,
   output reg multiproc_filter_enable,
   output reg receive_complete_flag,
   output reg shift_tick,
   output reg irq
);
   reg status_view_select;
   reg frame_error_flag;
   reg receive_overrun_flag;
   reg transmit_collision_flag;
   reg [3:0] irq_status;
   reg [3:0] irq_mask;
   reg rx_accept;
   reg [3:0] div_sel;
   reg [7:0] next_rdata;
   wire tick;
   wire wr_ctrl;
   wire [3:0] events;
   wire clear_window;

   // Register write decode, shared by every register
   function wr_hit;
      input wr_in;
      input [3:0] addr_in;
      input [3:0] target;
      begin
         wr_hit = wr_in && (addr_in == target);
      end
   endfunction

   // Sticky flag update: the hardware set wins over a software clear
   function sticky_next;
      input current;
      input set_evt;
      input clear_req;
      begin
         if (set_evt)
            sticky_next = 1'b1;
         else if (clear_req)
            sticky_next = 1'b0;
         else
            sticky_next = current;
      end
   endfunction

   assign wr_ctrl = wr_hit(wr, addr, `SPMF_ADDR_CTRL);
   assign clear_window = wr_ctrl && status_view_select;

   // Receive completion filter
   always @* begin
      case (serial_mode_select)
         `SPMF_MODE1: rx_accept = !multiproc_filter_enable || rx_stop_bit;
         `SPMF_MODE2, `SPMF_MODE3: rx_accept = !multiproc_filter_enable || rx_ninth_bit;
         default: rx_accept = 1'b1;
      endcase
   end

   // Mode 0 divide choice
   always @* begin
      if (multiproc_filter_enable)
         div_sel = `SPMF_DIV_FAST;
      else
         div_sel = `SPMF_DIV_SLOW;
   end

   spmf_divider u_div (
      .clock(clock),
      .rst(rst),
      .run(shift_active && (serial_mode_select == `SPMF_MODE0)),
      .divide_by(div_sel),
      .tick(tick)
   );

   assign events = {rx_done && rx_accept, collision_event, overrun_event, frame_error_event};

   // Control and status views
   always @(posedge clock) begin
      if (rst) begin
         serial_mode_select <= 2'h0;
         multiproc_filter_enable <= 1'b0;
         status_view_select <= 1'b0;
         frame_error_flag <= 1'b0;
         receive_overrun_flag <= 1'b0;
         transmit_collision_flag <= 1'b0;
         receive_complete_flag <= 1'b0;
      end else begin
         if (wr_ctrl && !status_view_select) begin
            serial_mode_select <= wdata[`SPMF_BIT_MODE_HI:`SPMF_BIT_MODE_LO];
            multiproc_filter_enable <= wdata[`SPMF_BIT_MP];
         end
         if (wr_hit(wr, addr, `SPMF_ADDR_VIEW))
            status_view_select <= wdata[0];
         frame_error_flag <= sticky_next(frame_error_flag, frame_error_event,
            clear_window && !wdata[`SPMF_BIT_FE]);
         receive_overrun_flag <= sticky_next(receive_overrun_flag, overrun_event,
            clear_window && !wdata[`SPMF_BIT_OV]);
         transmit_collision_flag <= sticky_next(transmit_collision_flag, collision_event,
            clear_window && !wdata[`SPMF_BIT_MP]);
         receive_complete_flag <= sticky_next(receive_complete_flag, rx_done && rx_accept,
            wr_hit(wr, addr, `SPMF_ADDR_CFG) && !wdata[0]);
      end
   end

   // Interrupt status, mask and output
   always @(posedge clock) begin
      if (rst) begin
         irq_status <= 4'h0;
         irq_mask <= 4'h0;
         irq <= 1'b0;
         shift_tick <= 1'b0;
      end else begin
         if (wr_hit(wr, addr, `SPMF_ADDR_STAT))
            irq_status <= (irq_status & ~wdata[3:0]) | events;
         else
            irq_status <= irq_status | events;
         if (wr_hit(wr, addr, `SPMF_ADDR_MASK))
            irq_mask <= wdata[3:0];
         irq <= |(irq_status & irq_mask);
         shift_tick <= tick;
      end
   end

   // Read mux
   always @* begin
      next_rdata = 8'h00;
      case (addr)
         `SPMF_ADDR_CTRL: begin
            if (status_view_select)
               next_rdata = {frame_error_flag, receive_overrun_flag, transmit_collision_flag, 5'h00};
            else
               next_rdata = {serial_mode_select, multiproc_filter_enable, 5'h00};
         end
         `SPMF_ADDR_VIEW: next_rdata = {7'h00, status_view_select};
         `SPMF_ADDR_STAT: next_rdata = {4'h0, irq_status};
         `SPMF_ADDR_MASK: next_rdata = {4'h0, irq_mask};
         `SPMF_ADDR_CFG: next_rdata = {7'h00, receive_complete_flag};
         default: next_rdata = 8'h00;
      endcase
   end

   always @(posedge clock) begin
      if (rst)
         rdata <= 8'h00;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end
endmodule // spmf_serial_mode

/* test/spmf_remote.sv */
// Remote serial device: bench commands become received-frame events
// Assumes cmd changes just after a rising edge
`timescale 1ns/100ps
module spmf_remote(input wire clock, input wire [5:0] cmd, output wire rx_done, rx_stop_bit, rx_ninth_bit,
   frame_error_event, overrun_event, collision_event);
   reg [5:0] q = 6'h00;
   assign {collision_event, overrun_event, frame_error_event, rx_ninth_bit, rx_stop_bit, rx_done} = q;
   // Stop and ninth bits toggle outside frames
   always @(posedge clock) q <= cmd[0] ? cmd : {cmd[5:3], ~q[2:1], 1'b0};
endmodule // spmf_remote

/* test/spmf_serial_mode_checker.sv */
// Assertions on the serial mode block ports
// Assumes a bind by port name from the bench top
`timescale 1ns/100ps
module spmf_chk(input wire clock, rst, wr, rd, frame_error_event, overrun_event, collision_event, rx_done,
   rx_stop_bit, rx_ninth_bit, shift_active, multiproc_filter_enable, receive_complete_flag, shift_tick,
   input wire [3:0] addr, input wire [7:0] wdata, rdata, input wire [1:0] serial_mode_select);
   reg v;
   reg [2:0] fl;
   wire mp = multiproc_filter_enable;
   wire r0 = rd && addr == 4'h0 && v;
   wire nf = rx_done && !wr && mp && !receive_complete_flag;
   always @(posedge clock) v <= rst ? 1'b0 : wr && addr == 4'h1 ? wdata[0] : v;
   // Expected error flags: set by events, cleared by a zero written in the flag view
   always @(posedge clock) fl <= rst ? 3'h0 : {frame_error_event, overrun_event, collision_event} |
      (fl & ~({3{wr && addr == 4'h0 && v}} & ~wdata[7:5]));
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_mode; wr && addr == 4'h0 && !v |=> {serial_mode_select, mp} == $past(wdata[7:5]); endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_fe; r0 |=> rdata[7] == $past(fl[2]); endproperty
   a_fe: assert property (p_fe) else $error("fe");
   property p_ov; r0 |=> rdata[6] == $past(fl[1]); endproperty
   a_ov: assert property (p_ov) else $error("ov");
   property p_col; r0 |=> rdata[5] == $past(fl[0]); endproperty
   a_col: assert property (p_col) else $error("col");
   property p_rx1; nf && serial_mode_select == 2'h1 && !rx_stop_bit |=> !receive_complete_flag; endproperty
   a_rx1: assert property (p_rx1) else $error("stop");
   property p_rx9; nf && serial_mode_select[1] && !rx_ninth_bit |=> !receive_complete_flag; endproperty
   a_rx9: assert property (p_rx9) else $error("ninth");
   property p_t12; shift_tick && shift_active && !mp |=> !shift_tick [*8]; endproperty
   a_t12: assert property (p_t12) else $error("slow");
   property p_t4; shift_tick && mp |-> ##4 (shift_tick || !shift_active || !mp); endproperty
   a_t4: assert property (p_t4) else $error("fast");
   cover property (nf);
   cover property (r0);
   cover property (shift_tick);
endmodule // spmf_chk

/* test/spmf_serial_mode_tb.sv */
// Bench for the serial mode block
// Assumes the remote model and checker beside it
`timescale 1ns/100ps
module spmf_serial_mode_tb;
   reg clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, shift_active = 1'b0, e;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   reg [5:0] cmd = 6'h00;
   reg [2:0] f = 3'h0;
   wire [7:0] rdata;
   wire [1:0] serial_mode_select;
   wire rx_done, rx_stop_bit, rx_ninth_bit, frame_error_event, overrun_event, collision_event, irq;
   wire multiproc_filter_enable, receive_complete_flag, shift_tick;
   integer num_errors = 0, n_compared = 0, i, m, b, n;
   spmf_serial_mode i_dut(.*);
   spmf_remote i_remote(.*);
   // Expected receive-complete outcome of one frame
   function exp_rx;
      input integer mode;
      input [31:0] bits;
      begin
         exp_rx = !bits[0] || (mode == 1 ? bits[1] : bits[2]);
      end
   endfunction
   task chk(input [7:0] g, x);
      begin
         n_compared = n_compared + 1;
         if (g !== x) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: %h", $time, g);
         end
      end
   endtask
   task bus(input w, input [3:0] a, input [7:0] d);
      begin
         @(posedge clock) {addr, wdata, wr, rd} <= {a, d, w, !w};
         @(posedge clock) {wr, rd} <= 2'b00;
         #1;
      end
   endtask
   task test_done;
      begin
         $display("%0d compared, %0d wrong", n_compared, num_errors);
         if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   initial forever #5 clock = ~clock;
   initial begin
      #20000 num_errors = num_errors + 1;
      test_done;
   end
   initial begin
      n = $urandom(69);
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 24; i = i + 1) begin
         m = 1 + i % 3;
         b = $urandom;
         e = exp_rx(m, b);
         f = (f | {b[3], b[4], b[5]}) & b[12:10];
         bus(1, 4'h0, {m[1:0], b[0], 5'h00});
         bus(0, 4'h0, 8'h00);
         chk(rdata[7:5], {m[1:0], b[0]});
         bus(1, 4'h2, 8'h0f);
         bus(1, 4'h3, {4'h0, b[9:6]});
         bus(1, 4'h4, 8'h00);
         @(posedge clock) cmd <= {b[5:1], 1'b1};
         @(posedge clock) cmd <= 6'h00;
         repeat (3) @(posedge clock);
         chk(receive_complete_flag, e);
         bus(1, 4'h1, 8'h01);
         bus(1, 4'h0, {b[12:10], 5'h00});
         bus(0, 4'h0, 8'h00);
         chk({rdata[7:5], serial_mode_select, irq}, {f, m[1:0], |({e, b[5:3]} & b[9:6])});
         bus(1, 4'h1, 8'h00);
      end
      $display("flag test end");
      for (b = 0; b < 2; b = b + 1) begin
         bus(1, 4'h0, {2'h0, b[0], 5'h00});
         @(posedge clock) shift_active <= 1'b1;
         repeat (12) @(posedge clock);
         n = 0;
         repeat (48) @(posedge clock) n = n + shift_tick;
         chk(n, b ? 12 : 4);
         shift_active <= 1'b0;
      end
      $display("tick test end");
      test_done;
   end
endmodule // spmf_serial_mode_tb
bind spmf_serial_mode spmf_chk i_chk(.*);
